// ### hdl/adc_control_result_regs.sv
`timescale 1ns/100ps
`include "conv_regs.svh"
module adc_control_result_regs #(
	parameter int RESULT_WIDTH  = 10,
	parameter int TRIGGER_COUNT = 16
) (
	// clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	// apb slave
	input  wire conv_pkg::apb_req_type      apb_in,
	output logic                            pready_out,
	output logic [31:0]                     prdata_out,
	output logic                            pslverr_out,
	// analog core
	output conv_pkg::core_req_type          core_out,
	input  wire logic                       core_done_in,
	input  wire logic [RESULT_WIDTH-1:0]    core_result_in,
	// trigger sources
	input  wire logic [TRIGGER_COUNT-1:0]   trigger_flags_in,
	// interrupt
	input  wire logic                       irq_ack_in,
	output logic                            irq_out
);

	// reset release
	logic [1:0]                    rst_sync_reg;
	logic                          rst_n;

	// registers
	logic [1:0]                    reference_select_reg;
	logic                          left_adjust_reg;
	logic [3:0]                    channel_select_reg;
	logic                          converter_enable_reg;
	logic                          start_conversion_bit_reg;
	logic                          auto_trigger_enable_reg;
	logic                          conversion_done_flag_reg;
	logic                          done_interrupt_enable_reg;
	logic [2:0]                    prescaler_select_reg;
	logic                          high_speed_mode_reg;
	logic                          amplified_start_request_reg;
	logic [3:0]                    trigger_source_select_reg;
	logic [RESULT_WIDTH-1:0]       result_reg;
	logic                          result_lock_reg;

	// conversion control
	conv_pkg::conv_state_type      state_reg;
	logic                          enabled_reg;
	logic                          init_pending_reg;
	logic [1:0]                    work_reference_reg;
	logic [3:0]                    work_channel_reg;
	logic [6:0]                    presc_count_reg;
	logic                          trigger_prev_reg;

	// bus decode
	conv_pkg::reg_sel_type         sel;
	logic                          access_phase;
	logic                          complete;
	logic                          wr;
	logic                          rd;
	logic [7:0]                    wbyte;
	logic                          go;
	logic                          done;
	logic                          trigger_edge;
	logic                          free_restart;
	logic [6:0]                    presc_last;
	logic [7:0]                    result_low_byte;
	logic [7:0]                    result_high_byte;
	logic                          flag_set;
	logic                          flag_clear;

	function automatic conv_pkg::reg_sel_type decode(input logic [7:0] addr);
		case (addr)
			`CONV_OFF_INPUT_SELECT: decode = conv_pkg::SEL_INPUT;
			`CONV_OFF_CONTROL_A:    decode = conv_pkg::SEL_CTRL_A;
			`CONV_OFF_CONTROL_B:    decode = conv_pkg::SEL_CTRL_B;
			`CONV_OFF_RESULT_LOW:   decode = conv_pkg::SEL_LOW;
			`CONV_OFF_RESULT_HIGH:  decode = conv_pkg::SEL_HIGH;
			default:                decode = conv_pkg::SEL_NONE;
		endcase
	endfunction : decode

	// reset synchroniser
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// bus phases
	assign sel          = decode(apb_in.paddr);
	assign access_phase = apb_in.psel & apb_in.penable;
	assign complete     = access_phase & pready_out & (sel != conv_pkg::SEL_NONE);
	assign wr           = complete & apb_in.pwrite;
	assign rd           = complete & ~apb_in.pwrite;
	assign wbyte        = apb_in.pwdata[7:0];

	// result byte views, alignment follows left adjust live
	always_comb begin
		if (left_adjust_reg) begin
			result_high_byte = result_reg[9:2];
			result_low_byte  = {result_reg[1:0], 6'h00};
		end else begin
			result_high_byte = {6'h00, result_reg[9:8]};
			result_low_byte  = result_reg[7:0];
		end
	end

	// apb answer, one wait state
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= access_phase & ~pready_out;
			pslverr_out <= access_phase & ~pready_out & (sel == conv_pkg::SEL_NONE);
			if (access_phase && !pready_out) begin
				case (sel)
					conv_pkg::SEL_INPUT:
						prdata_out <= {24'h00_0000, reference_select_reg, left_adjust_reg,
							1'b0, channel_select_reg};
					conv_pkg::SEL_CTRL_A:
						prdata_out <= {24'h00_0000, converter_enable_reg,
							start_conversion_bit_reg, auto_trigger_enable_reg,
							conversion_done_flag_reg, done_interrupt_enable_reg,
							prescaler_select_reg};
					conv_pkg::SEL_CTRL_B:
						prdata_out <= {24'h00_0000, high_speed_mode_reg, 2'h0,
							amplified_start_request_reg, trigger_source_select_reg};
					conv_pkg::SEL_LOW:  prdata_out <= {24'h00_0000, result_low_byte};
					conv_pkg::SEL_HIGH: prdata_out <= {24'h00_0000, result_high_byte};
					default:            prdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// input select register
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			reference_select_reg <= 2'h0;
			left_adjust_reg      <= 1'b0;
			channel_select_reg   <= 4'h0;
		end else if (wr && sel == conv_pkg::SEL_INPUT) begin
			reference_select_reg <= wbyte[`CONV_IS_REF_HI:`CONV_IS_REF_LO];
			left_adjust_reg      <= wbyte[`CONV_IS_LEFT];
			channel_select_reg   <= wbyte[`CONV_IS_CH_HI:`CONV_IS_CH_LO];
		end
	end

	// control a static fields
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			converter_enable_reg      <= 1'b0;
			auto_trigger_enable_reg   <= 1'b0;
			done_interrupt_enable_reg <= 1'b0;
			prescaler_select_reg      <= 3'h0;
		end else if (wr && sel == conv_pkg::SEL_CTRL_A) begin
			converter_enable_reg      <= wbyte[`CONV_CA_ENABLE];
			auto_trigger_enable_reg   <= wbyte[`CONV_CA_AUTO];
			done_interrupt_enable_reg <= wbyte[`CONV_CA_IE];
			prescaler_select_reg      <= wbyte[`CONV_CA_PS_HI:`CONV_CA_PS_LO];
		end
	end

	// control b register, amplified request cleared once its conversion starts
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			high_speed_mode_reg         <= 1'b0;
			amplified_start_request_reg <= 1'b0;
			trigger_source_select_reg   <= 4'h0;
		end else begin
			if (wr && sel == conv_pkg::SEL_CTRL_B) begin
				high_speed_mode_reg       <= wbyte[`CONV_CB_HSM];
				trigger_source_select_reg <= wbyte[`CONV_CB_TRG_HI:`CONV_CB_TRG_LO];
			end
			if (wr && sel == conv_pkg::SEL_CTRL_B && wbyte[`CONV_CB_AMP_REQ]) begin
				amplified_start_request_reg <= 1'b1;
			end else if (go) begin
				amplified_start_request_reg <= 1'b0;
			end else if (wr && sel == conv_pkg::SEL_CTRL_B) begin
				amplified_start_request_reg <= 1'b0;
			end
		end
	end

	// auto trigger edge detect on the selected source
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			trigger_prev_reg <= 1'b0;
		end else begin
			trigger_prev_reg <= trigger_flags_in[trigger_source_select_reg];
		end
	end
	assign trigger_edge = auto_trigger_enable_reg
		& (trigger_source_select_reg != `CONV_TRG_FREE_RUN)
		& trigger_flags_in[trigger_source_select_reg] & ~trigger_prev_reg;
	assign done         = (state_reg == conv_pkg::CONV_RUN) & core_done_in;
	assign free_restart = done & auto_trigger_enable_reg & converter_enable_reg
		& (trigger_source_select_reg == `CONV_TRG_FREE_RUN);
	assign go = (state_reg == conv_pkg::CONV_IDLE) & enabled_reg & converter_enable_reg
		& (start_conversion_bit_reg | amplified_start_request_reg);

	// start bit: software or trigger sets, completion clears, zero write ignored
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			start_conversion_bit_reg <= 1'b0;
		end else if ((wr && sel == conv_pkg::SEL_CTRL_A && wbyte[`CONV_CA_START])
				|| trigger_edge || free_restart) begin
			start_conversion_bit_reg <= 1'b1;
		end else if (done) begin
			start_conversion_bit_reg <= 1'b0;
		end
	end

	// effective enable only follows the bit between conversions
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			enabled_reg      <= 1'b0;
			init_pending_reg <= 1'b0;
		end else begin
			if (state_reg == conv_pkg::CONV_IDLE || done) begin
				enabled_reg <= converter_enable_reg;
			end
			if (!enabled_reg && converter_enable_reg
					&& (state_reg == conv_pkg::CONV_IDLE || done)) begin
				init_pending_reg <= 1'b1;
			end else if (go) begin
				init_pending_reg <= 1'b0;
			end
		end
	end

	// conversion sequencing
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg          <= conv_pkg::CONV_IDLE;
			work_reference_reg <= `CONV_REF_EXTERNAL;
			work_channel_reg   <= 4'h0;
		end else begin
			case (state_reg)
				conv_pkg::CONV_IDLE: begin
					if (go) begin
						state_reg          <= conv_pkg::CONV_RUN;
						work_reference_reg <= reference_select_reg;
						work_channel_reg   <= channel_select_reg;
					end
				end
				conv_pkg::CONV_RUN: begin
					if (core_done_in) begin
						state_reg <= conv_pkg::CONV_IDLE;
					end
				end
				default: state_reg <= conv_pkg::CONV_IDLE;
			endcase
		end
	end

	// result capture and read lock
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			result_reg      <= `CONV_RES_ZERO;
			result_lock_reg <= 1'b0;
		end else begin
			if (done && !result_lock_reg) begin
				result_reg <= core_result_in;
			end
			if (rd && sel == conv_pkg::SEL_LOW) begin
				result_lock_reg <= 1'b1;
			end else if (rd && sel == conv_pkg::SEL_HIGH) begin
				result_lock_reg <= 1'b0;
			end
		end
	end

	// done flag, set wins over clear
	assign flag_set   = done & ~result_lock_reg;
	assign flag_clear = irq_ack_in
		| (wr && sel == conv_pkg::SEL_CTRL_A && wbyte[`CONV_CA_DONE]);
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			conversion_done_flag_reg <= 1'b0;
		end else if (flag_set) begin
			conversion_done_flag_reg <= 1'b1;
		end else if (flag_clear) begin
			conversion_done_flag_reg <= 1'b0;
		end
	end

	// interrupt request
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= conversion_done_flag_reg & done_interrupt_enable_reg;
		end
	end

	// prescaler
	assign presc_last = (prescaler_select_reg == 3'h0) ? 7'h01
		: 7'((8'h01 << prescaler_select_reg) - 8'h01);
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			presc_count_reg <= 7'h00;
		end else if (!enabled_reg || presc_count_reg >= presc_last) begin
			presc_count_reg <= 7'h00;
		end else begin
			presc_count_reg <= presc_count_reg + 7'h01;
		end
	end

	// core request outputs
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			core_out <= '0;
		end else begin
			core_out.start      <= go;
			core_out.init       <= go ? init_pending_reg : core_out.init;
			core_out.reference  <= go ? reference_select_reg : work_reference_reg;
			core_out.channel    <= go ? channel_select_reg : work_channel_reg;
			core_out.internal_ref_on <= enabled_reg
				& (((state_reg == conv_pkg::CONV_RUN) ? work_reference_reg
				: reference_select_reg) == `CONV_REF_INTERNAL);
			core_out.clk_en     <= enabled_reg & (presc_count_reg >= presc_last);
			core_out.enable     <= enabled_reg;
			core_out.high_speed <= high_speed_mode_reg;
		end
	end

endmodule : adc_control_result_regs

// ### hdl/conv_pkg.sv
package conv_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic       start;
		logic       init;
		logic [1:0] reference;
		logic [3:0] channel;
		logic       internal_ref_on;
		logic       clk_en;
		logic       enable;
		logic       high_speed;
	} core_req_type;

	typedef enum logic [0:0] {
		CONV_IDLE,
		CONV_RUN
	} conv_state_type;

	typedef enum logic [2:0] {
		SEL_INPUT,
		SEL_CTRL_A,
		SEL_CTRL_B,
		SEL_LOW,
		SEL_HIGH,
		SEL_NONE
	} reg_sel_type;

endpackage : conv_pkg

// ### hdl/conv_regs.svh
`ifndef CONV_REGS_SVH
`define CONV_REGS_SVH

// register byte addresses
`define CONV_OFF_INPUT_SELECT 8'h00
`define CONV_OFF_CONTROL_A    8'h04
`define CONV_OFF_CONTROL_B    8'h08
`define CONV_OFF_RESULT_LOW   8'h0C
`define CONV_OFF_RESULT_HIGH  8'h10

// reset values
`define CONV_RST_INPUT_SELECT 8'h00
`define CONV_RST_CONTROL_A    8'h00
`define CONV_RST_CONTROL_B    8'h00

// input select fields
`define CONV_IS_REF_HI   7
`define CONV_IS_REF_LO   6
`define CONV_IS_LEFT     5
`define CONV_IS_CH_HI    3
`define CONV_IS_CH_LO    0

// control a fields
`define CONV_CA_ENABLE   7
`define CONV_CA_START    6
`define CONV_CA_AUTO     5
`define CONV_CA_DONE     4
`define CONV_CA_IE       3
`define CONV_CA_PS_HI    2
`define CONV_CA_PS_LO    0

// control b fields
`define CONV_CB_HSM      7
`define CONV_CB_AMP_REQ  4
`define CONV_CB_TRG_HI   3
`define CONV_CB_TRG_LO   0

// reference encodings
`define CONV_REF_EXTERNAL 2'h0
`define CONV_REF_SUPPLY   2'h1
`define CONV_REF_RESERVED 2'h2
`define CONV_REF_INTERNAL 2'h3

// channel encodings
`define CONV_CH_INPUT_LAST 4'hA
`define CONV_CH_GAIN_ZERO  4'hB
`define CONV_CH_GAIN_ONE   4'hC
`define CONV_CH_RESERVED   4'hD
`define CONV_CH_BANDGAP    4'hE
`define CONV_CH_GROUND     4'hF

// trigger source code for free running
`define CONV_TRG_FREE_RUN  4'h0

// result codes
`define CONV_RES_ZERO      10'h000
`define CONV_RES_FULL      10'h3FF
`define CONV_RES_SIGN      9

`endif

// ### tb/conv_asserts.sv
`timescale 1ns/100ps
module conv_asserts #(
	parameter int RESULT_WIDTH  = 10,
	parameter int TRIGGER_COUNT = 16
) (
	// clock and reset
	input wire logic                     clk_in,
	input wire logic                     rst_n_in,
	// apb slave
	input wire conv_pkg::apb_req_type    apb_in,
	input wire logic                     pready_out,
	input wire logic [31:0]              prdata_out,
	input wire logic                     pslverr_out,
	// analog core
	input wire conv_pkg::core_req_type   core_out,
	input wire logic                     core_done_in,
	input wire logic [RESULT_WIDTH-1:0]  core_result_in,
	// triggers and interrupt
	input wire logic [TRIGGER_COUNT-1:0] trigger_flags_in,
	input wire logic                     irq_ack_in,
	input wire logic                     irq_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence access_s;
		apb_in.psel && apb_in.penable && !pready_out;
	endsequence
	sequence conv_start_s;
		core_out.start;
	endsequence
	ready_one_wait_a: assert property (access_s |=> pready_out) else $error("ready late");
	ready_in_access_a: assert property (pready_out |-> apb_in.psel && apb_in.penable)
		else $error("ready outside access");
	err_with_ready_a: assert property (pslverr_out |-> pready_out) else $error("stray error");
	rdata_upper_a: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
		else $error("upper read bits set");
	start_pulse_a: assert property (conv_start_s |=> !core_out.start) else $error("start long");
	start_enabled_a: assert property (conv_start_s |-> core_out.enable)
		else $error("start while disabled");
	sel_hold_a: assert property (conv_start_s |=>
		($stable(core_out.channel) && $stable(core_out.reference)) until core_done_in)
		else $error("selection moved mid conversion");
	tick_pulse_a: assert property (core_out.clk_en |=> !core_out.clk_en)
		else $error("clock enable long");
	tick_enabled_a: assert property (core_out.clk_en |-> core_out.enable)
		else $error("prescaler runs disabled");
	ref_enabled_a: assert property (core_out.internal_ref_on |-> core_out.enable)
		else $error("reference on while disabled");
	irq_clear_a: assert property (irq_ack_in && !core_done_in |-> ##2 !irq_out)
		else $error("irq stays after ack");
endmodule : conv_asserts

bind adc_control_result_regs conv_asserts #(
	.RESULT_WIDTH(RESULT_WIDTH),
	.TRIGGER_COUNT(TRIGGER_COUNT)
) chk (.clk_in, .rst_n_in, .apb_in, .pready_out, .prdata_out, .pslverr_out, .core_out,
	.core_done_in, .core_result_in, .trigger_flags_in, .irq_ack_in, .irq_out);

// ### tb/core_model.sv
`timescale 1ns/100ps
module core_model (
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	// request and scenario settings
	input  wire conv_pkg::core_req_type req_in,
	input  wire logic [9:0]             code_in,
	input  wire logic [3:0]             ticks_in,
	// answer and observations
	output logic                        done_out,
	output logic [9:0]                  result_out,
	output logic [3:0]                  channel_out,
	output logic                        init_out
);
	logic [3:0] count_reg;
	logic       busy_reg;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_reg <= 1'b0;
			count_reg <= 4'h0;
			done_out <= 1'b0;
			result_out <= 10'h000;
			channel_out <= 4'h0;
			init_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			result_out <= ~result_out;
			if (req_in.start) begin
				busy_reg <= 1'b1;
				count_reg <= ticks_in;
				init_out <= req_in.init;
			end else if (busy_reg && req_in.clk_en) begin
				if (count_reg == 4'h0) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
					result_out <= code_in;
					channel_out <= req_in.channel;
				end else begin
					count_reg <= count_reg - 4'h1;
				end
			end
		end
	end
endmodule : core_model

// ### tb/tb.sv
`timescale 1ns/100ps
`include "conv_regs.svh"
module tb;
	logic                   clk_in;
	logic                   rst_n_in;
	conv_pkg::apb_req_type  apb_in;
	logic                   pready_out;
	logic [31:0]            prdata_out;
	logic                   pslverr_out;
	conv_pkg::core_req_type core_out;
	logic                   core_done_in;
	logic [9:0]             core_result_in;
	logic [15:0]            trigger_flags_in;
	logic                   irq_ack_in;
	logic                   irq_out;
	logic [9:0]             code;
	logic [3:0]             ticks;
	logic [3:0]             seen_ch;
	logic                   seen_init;
	logic [31:0]            rd;
	logic                   err;
	int                     failures;
	int                     num_checks;
	int                     gap;
	adc_control_result_regs DUT (.clk_in, .rst_n_in, .apb_in, .pready_out, .prdata_out,
		.pslverr_out, .core_out, .core_done_in, .core_result_in, .trigger_flags_in,
		.irq_ack_in, .irq_out);
	core_model partner (.clk_in, .rst_n_in, .req_in(core_out), .code_in(code),
		.ticks_in(ticks), .done_out(core_done_in), .result_out(core_result_in),
		.channel_out(seen_ch), .init_out(seen_init));
	always #5 clk_in = ~clk_in;
	task automatic complete_run;
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_in);
		apb_in.penable <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1 && ++k < 20);
		rd = prdata_out;
		err = pslverr_out;
		apb_in <= '0;
		if (k >= 20) failures++;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h000000, d});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h00000000);
		check(rd, {24'h000000, e});
	endtask : rdc
	task automatic wait_core;
		int k;
		k = 0;
		do @(posedge clk_in); while (core_done_in !== 1'b1 && ++k < 500);
		if (k >= 500) failures++;
		repeat (2) @(posedge clk_in);
	endtask : wait_core
	task automatic pulse_gap(output int g);
		int k;
		k = 0;
		do @(posedge clk_in); while (core_out.clk_en !== 1'b1 && ++k < 300);
		g = 0;
		do begin
			@(posedge clk_in);
			g++;
		end while (core_out.clk_en !== 1'b1 && g < 300);
	endtask : pulse_gap
	initial begin
		#100000;
		failures++;
		complete_run();
	end
	initial begin
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		apb_in = '0;
		code = 10'h270;
		ticks = 4'h2;
		trigger_flags_in = 16'h0000;
		irq_ack_in = 1'b0;
		failures = 0;
		num_checks = 0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rdc(`CONV_OFF_INPUT_SELECT, 8'h00);
		rdc(`CONV_OFF_CONTROL_A, 8'h00);
		rdc(`CONV_OFF_CONTROL_B, 8'h00);
		xfer(1'b0, 8'h14, 32'h00000000);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// channel 3, internal reference, left adjusted, interrupt on
		wr(`CONV_OFF_INPUT_SELECT, 8'hE3);
		wr(`CONV_OFF_CONTROL_A, 8'hCA);
		wait_core();
		check({31'h0, seen_init}, 32'h1);
		check({30'h0, core_out.reference}, 32'h3);
		check({31'h0, core_out.internal_ref_on}, 32'h1);
		rdc(`CONV_OFF_CONTROL_A, 8'h9A);
		check({31'h0, irq_out}, 32'h1);
		rdc(`CONV_OFF_RESULT_LOW, 8'h00);
		rdc(`CONV_OFF_RESULT_HIGH, 8'h9C);
		wr(`CONV_OFF_INPUT_SELECT, 8'hC3);
		rdc(`CONV_OFF_RESULT_LOW, 8'h70);
		rdc(`CONV_OFF_RESULT_HIGH, 8'h02);
		wr(`CONV_OFF_CONTROL_A, 8'h8A);
		rdc(`CONV_OFF_CONTROL_A, 8'h9A);
		@(posedge clk_in);
		irq_ack_in <= 1'b1;
		@(posedge clk_in);
		irq_ack_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		check({31'h0, irq_out}, 32'h0);
		rdc(`CONV_OFF_CONTROL_A, 8'h8A);
		// selection change while converting
		code <= 10'h3FF;
		ticks <= 4'h8;
		wr(`CONV_OFF_CONTROL_A, 8'hC2);
		wr(`CONV_OFF_INPUT_SELECT, 8'h05);
		wait_core();
		check({28'h0, seen_ch}, 32'h3);
		check({31'h0, seen_init}, 32'h0);
		check({31'h0, irq_out}, 32'h0);
		wr(`CONV_OFF_CONTROL_A, 8'h92);
		rdc(`CONV_OFF_CONTROL_A, 8'h82);
		// low byte read holds the pair
		rdc(`CONV_OFF_RESULT_LOW, 8'hFF);
		code <= 10'h155;
		ticks <= 4'h2;
		wr(`CONV_OFF_CONTROL_A, 8'hC2);
		wait_core();
		check({28'h0, seen_ch}, 32'h5);
		xfer(1'b0, `CONV_OFF_CONTROL_A, 32'h0);
		check({31'h0, rd[4]}, 32'h0);
		rdc(`CONV_OFF_RESULT_HIGH, 8'h03);
		// auto trigger from source 3 only
		code <= 10'h0AA;
		wr(`CONV_OFF_CONTROL_B, 8'h03);
		wr(`CONV_OFF_CONTROL_A, 8'hA2);
		@(posedge clk_in);
		trigger_flags_in <= 16'h0004;
		repeat (40) @(posedge clk_in);
		rdc(`CONV_OFF_CONTROL_A, 8'hA2);
		trigger_flags_in <= 16'h000C;
		wait_core();
		rdc(`CONV_OFF_RESULT_LOW, 8'hAA);
		rdc(`CONV_OFF_RESULT_HIGH, 8'h00);
		// prescaler division for every code
		for (int c = 0; c < 8; c++) begin
			wr(`CONV_OFF_CONTROL_A, {5'h10, c[2:0]});
			pulse_gap(gap);
			check(gap, (c < 2) ? 32'd2 : (32'd1 << c));
		end
		// amplified request starts a conversion and clears, high speed kept
		wr(`CONV_OFF_CONTROL_B, 8'h90);
		wait_core();
		rdc(`CONV_OFF_CONTROL_B, 8'h80);
		check({31'h0, core_out.high_speed}, 32'h1);
		complete_run();
	end
endmodule : tb
